/* File: rtl/psd_pkg.sv */
package psd_pkg;

    // ************************************************************
    // Register map, byte addresses on the APB
    // ************************************************************
    localparam logic [7:0] PORT1_BASE = 8'h00; // Block of port 1 registers
    localparam logic [7:0] PORT2_BASE = 8'h20; // Block of port 2 registers
    localparam logic [4:0] OFS_BASIC = 5'h00; // phy_basic_ctrl_reg
    localparam logic [4:0] OFS_ADV = 5'h04; // phy_advertisement_reg
    localparam logic [4:0] OFS_MODES = 5'h08; // phy_special_modes_reg
    localparam logic [4:0] OFS_PAUSE = 5'h0C; // Manual flow control register
    localparam logic [4:0] OFS_XCTL = 5'h10; // phy_special_ctrl_status_reg
    localparam logic [7:0] ADDR_STRAPS = 8'h40; // Latched strap image, read only

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int BIT_RATE = 13; // phy_rate_select_low_bit
    localparam int BIT_NEG = 12; // phy_negotiation_enable_bit
    localparam int BIT_DUPLEX = 8; // mode_bit_a
    localparam int BIT_SYM_PAUSE = 10; // Symmetric pause advertised
    localparam int BIT_ADV_10FD = 6; // 10BASE-T full duplex advertised
    localparam int BIT_ADV_10HD = 5; // 10BASE-T half duplex advertised
    localparam int BIT_MODE_LO = 5; // Lowest bit of the mode field
    localparam int BIT_RX_PAUSE = 0; // Receive pause enable
    localparam int BIT_TX_PAUSE = 1; // Transmit pause enable
    localparam int BIT_BACKPR = 2; // Backpressure enable
    localparam int BIT_MANUAL = 3; // Manual pause select
    localparam int BIT_XOVR_CTL = 15; // crossover_override_ctl
    localparam int BIT_XOVR_AUTO = 14; // Automatic crossover when overridden
    localparam int BIT_XOVR_MDIX = 13; // MDIX select when overridden

    // ************************************************************
    // Values after reset, before the straps land
    // ************************************************************
    localparam logic [15:0] RST_BASIC = 16'h0000; // Basic control
    localparam logic [15:0] RST_ADV = 16'h0000; // Advertisement
    localparam logic [15:0] RST_MODES = 16'h0000; // Special modes
    localparam logic [15:0] RST_PAUSE = 16'h0000; // Manual flow control
    localparam logic [15:0] RST_XCTL = 16'h0000; // Special control/status
    localparam logic [2:0] MODE_ALL_CAPABLE = 3'h7; // Mode when negotiating

    // Port 1 has no strap for these; fixed defaults instead
    localparam logic P1_NEG_DEFAULT = 1'h1;
    localparam logic P1_RATE_DEFAULT = 1'h1;
    localparam logic P1_XOVR_AUTO_DEFAULT = 1'h1;
    localparam logic P1_XOVR_MDIX_DEFAULT = 1'h0;

    // ************************************************************
    // Strap load timing
    // ************************************************************
    localparam logic [1:0] LOAD_DONE = 2'h3; // Edges of loading after release

    // Load sequencer states
    typedef enum logic [0:0] {
        LD_LOADING = 1'b0,
        LD_IDLE = 1'b1
    } psd_load_t;

endpackage

/* File: rtl/psd_strap_defaults.sv */
`timescale 1ns/100ps
`default_nettype none
// What this block does
// RULE1: Crossover strap sets automatic crossover default
// RULE2: Override bit set ignores the crossover strap
// RULE3: Manual strap picks MDI or MDIX
// RULE4: Duplex strap sets basic control duplex default
// RULE5: Duplex strap shapes 10FD advertisement and mode
// RULE6: Backpressure strap sets backpressure enable default
// RULE7: Pause strap sets transmit and receive enables
// RULE8: Manual pause high: bits rule, no symmetric
// RULE9: Manual pause low: negotiation, symmetric advertised
// RULE10: Negotiation strap sets negotiation enable default
// RULE11: Negotiation strap shapes rate, duplex, advertisement, mode; here the rate and duplex defaults follow their own straps only
// RULE12: Rate strap sets rate select default
// RULE13: Rate strap shapes advertisement and mode
// RULE14: Straps load once at reset; writes win afterwards
module psd_strap_defaults (
    input wire logic MCLK,
    input wire logic RESET,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Strap pins, index 0 is port 1, index 1 is port 2
    input wire logic [1:0] STRAP_DUPLEX,
    input wire logic [1:0] STRAP_BACKPRESSURE,
    input wire logic [1:0] STRAP_FD_PAUSE,
    input wire logic [1:0] STRAP_MANUAL_PAUSE,
    input wire logic STRAP_XOVER_AUTO_P2,
    input wire logic STRAP_XOVER_MDIX_P2,
    input wire logic STRAP_NEGOTIATION_P2,
    input wire logic STRAP_RATE_P2,
    // Effective controls per port
    output logic [1:0] MODE_BIT_A_FULL,
    output logic [1:0] PHY_NEG_ENABLE,
    output logic [1:0] PHY_RATE_100,
    output logic [1:0] PAUSE_TX_EN,
    output logic [1:0] PAUSE_RX_EN,
    output logic [1:0] PAUSE_BY_NEG,
    output logic [1:0] BACKPRESSURE_EN,
    output logic [1:0] ADV_SYM_PAUSE,
    output logic [1:0] XOVER_AUTO,
    output logic [1:0] XOVER_MDIX,
    output logic LOAD_BUSY
);

    // ************************************************************
    // Strap synchroniser
    // ************************************************************
    logic [11:0] strap_raw; // All strap pins in one word
    logic [11:0] strap_meta_r; // First stage, read by the second only
    logic [11:0] strap_sync_r; // Second stage, safe to use
    logic [11:0] strap_r; // Straps as captured at load

    assign strap_raw = {STRAP_RATE_P2, STRAP_NEGOTIATION_P2, STRAP_XOVER_MDIX_P2,
                        STRAP_XOVER_AUTO_P2, STRAP_MANUAL_PAUSE, STRAP_FD_PAUSE,
                        STRAP_BACKPRESSURE, STRAP_DUPLEX};

    // Left without reset so the chain fills while reset is held
    always_ff @(posedge MCLK) begin
        strap_meta_r <= strap_raw;
        strap_sync_r <= strap_meta_r;
    end

    // ************************************************************
    // Load sequencer
    // ************************************************************
    psd_pkg::psd_load_t ld_state_r; // Loading or done
    logic [1:0] ld_cnt_r; // Edges spent loading
    logic loading; // Defaults are being written

    assign loading = (ld_state_r == psd_pkg::LD_LOADING);

    // Loads over several edges so the sync chain is certainly full
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            ld_state_r <= psd_pkg::LD_LOADING;
            ld_cnt_r <= 2'h0;
        end else begin
            case (ld_state_r)
                psd_pkg::LD_LOADING: begin
                    ld_cnt_r <= ld_cnt_r + 2'h1;
                    if (ld_cnt_r == psd_pkg::LOAD_DONE - 2'h1) begin
                        ld_state_r <= psd_pkg::LD_IDLE; // RULE14
                    end
                end
                psd_pkg::LD_IDLE: begin
                    ld_cnt_r <= ld_cnt_r; // Never leaves until next reset
                end
                default: begin
                    ld_state_r <= psd_pkg::LD_LOADING;
                end
            endcase
        end
    end

    // Strap image only refreshed while loading
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            strap_r <= 12'h000;
        end else if (loading) begin
            strap_r <= strap_sync_r; // RULE14
        end
    end

    // ************************************************************
    // APB access decode
    // ************************************************************
    logic pready_r; // Access phase answered
    logic pslverr_r; // Error answered: unmapped address or strap image write
    logic [31:0] prdata_r; // Read data held for the answer
    logic access_first; // First access cycle, before the answer
    logic wr_commit; // Edge at which a write lands
    logic addr_hit; // Address maps to a register
    logic [15:0] rd_word; // Selected register value
    logic [15:0] wmask; // Byte lanes allowed by PSTRB
    logic [1:0] wr_port; // One-hot port of the write target

    assign access_first = PSEL && PENABLE && !pready_r;
    // Writes ignored while defaults load; the bus still gets its normal one-wait answer
    assign wr_commit = PSEL && PENABLE && pready_r && PWRITE && !pslverr_r && !loading;
    assign wmask = {{8{PSTRB[1]}}, {8{PSTRB[0]}}};
    assign wr_port = {PADDR[5], !PADDR[5]};

    // ************************************************************
    // Per-port registers and defaults
    // ************************************************************
    logic [15:0] basic_r [2]; // phy_basic_ctrl_reg
    logic [15:0] adv_r [2]; // phy_advertisement_reg
    logic [15:0] modes_r [2]; // phy_special_modes_reg
    logic [15:0] pause_r [2]; // Manual flow control register
    logic [15:0] xctl_r [2]; // phy_special_ctrl_status_reg

    genvar p;
    generate
        for (p = 0; p < 2; p = p + 1) begin : g_port
            logic dpx; // Duplex strap
            logic neg; // Negotiation strap or fixed default
            logic rate; // Rate strap or fixed default
            logic x_auto; // Crossover enable strap or fixed default
            logic x_mdix; // Manual crossover strap or fixed default
            logic [15:0] d_basic; // Default of basic control
            logic [15:0] d_adv; // Default of advertisement
            logic [15:0] d_modes; // Default of special modes
            logic [15:0] d_pause; // Default of manual flow control
            logic hit_blk; // Write landing in this port's block
            logic xo; // Crossover override in force
            logic manual; // Manual pause selected

            assign dpx = strap_sync_r[p];
            assign neg = (p == 1) ? strap_sync_r[10] : psd_pkg::P1_NEG_DEFAULT;
            assign rate = (p == 1) ? strap_sync_r[11] : psd_pkg::P1_RATE_DEFAULT;
            assign x_auto = (p == 1) ? strap_r[8] : psd_pkg::P1_XOVR_AUTO_DEFAULT;
            assign x_mdix = (p == 1) ? strap_r[9] : psd_pkg::P1_XOVR_MDIX_DEFAULT;
            assign hit_blk = wr_commit && wr_port[p];

            // Basic control defaults from rate, negotiation and duplex
            always_comb begin
                d_basic = psd_pkg::RST_BASIC;
                d_basic[psd_pkg::BIT_RATE] = rate; // RULE12 RULE11
                d_basic[psd_pkg::BIT_NEG] = neg; // RULE10
                d_basic[psd_pkg::BIT_DUPLEX] = dpx; // RULE4 RULE11
            end

            // Advertisement: 10 Mbps abilities only when 10 Mbps is possible
            always_comb begin
                d_adv = psd_pkg::RST_ADV;
                d_adv[psd_pkg::BIT_ADV_10FD] = dpx && (neg || !rate); // RULE5 RULE11 RULE13
                d_adv[psd_pkg::BIT_ADV_10HD] = neg || !rate; // RULE11 RULE13
                // Symmetric pause only when negotiation resolves pause
                d_adv[psd_pkg::BIT_SYM_PAUSE] = !strap_sync_r[6 + p]; // RULE8 RULE9
            end

            // Mode field: all capable when negotiating, else forced rate/duplex
            always_comb begin
                d_modes = psd_pkg::RST_MODES;
                if (neg) begin
                    d_modes[psd_pkg::BIT_MODE_LO +: 3] = psd_pkg::MODE_ALL_CAPABLE; // RULE11
                end else begin
                    d_modes[psd_pkg::BIT_MODE_LO +: 3] = {1'b0, rate, dpx}; // RULE5 RULE13
                end
            end

            // Manual flow control defaults
            always_comb begin
                d_pause = psd_pkg::RST_PAUSE;
                d_pause[psd_pkg::BIT_RX_PAUSE] = strap_sync_r[4 + p]; // RULE7
                d_pause[psd_pkg::BIT_TX_PAUSE] = strap_sync_r[4 + p]; // RULE7
                d_pause[psd_pkg::BIT_BACKPR] = strap_sync_r[2 + p]; // RULE6
                d_pause[psd_pkg::BIT_MANUAL] = strap_sync_r[6 + p]; // RULE8 RULE9
            end

            // Registers: defaults while loading, software writes after
            always_ff @(posedge MCLK or posedge RESET) begin
                if (RESET) begin
                    basic_r[p] <= psd_pkg::RST_BASIC;
                    adv_r[p] <= psd_pkg::RST_ADV;
                    modes_r[p] <= psd_pkg::RST_MODES;
                    pause_r[p] <= psd_pkg::RST_PAUSE;
                end else if (loading) begin
                    basic_r[p] <= d_basic; // RULE14
                    adv_r[p] <= d_adv;
                    modes_r[p] <= d_modes;
                    pause_r[p] <= d_pause;
                end else if (hit_blk) begin
                    // Masked merge keeps lanes that PSTRB leaves out
                    case (PADDR[4:0])
                        psd_pkg::OFS_BASIC: begin
                            basic_r[p] <= (basic_r[p] & ~wmask) | (PWDATA[15:0] & wmask);
                        end
                        psd_pkg::OFS_ADV: begin
                            adv_r[p] <= (adv_r[p] & ~wmask) | (PWDATA[15:0] & wmask);
                        end
                        psd_pkg::OFS_MODES: begin
                            modes_r[p] <= (modes_r[p] & ~wmask) | (PWDATA[15:0] & wmask);
                        end
                        psd_pkg::OFS_PAUSE: begin
                            pause_r[p] <= (pause_r[p] & ~wmask) | (PWDATA[15:0] & wmask);
                        end
                        default: begin
                            basic_r[p] <= basic_r[p];
                        end
                    endcase
                end
            end

            // Override register is software only; straps never touch it
            always_ff @(posedge MCLK or posedge RESET) begin
                if (RESET) begin
                    xctl_r[p] <= psd_pkg::RST_XCTL;
                end else if (hit_blk && PADDR[4:0] == psd_pkg::OFS_XCTL) begin
                    xctl_r[p] <= (xctl_r[p] & ~wmask) | (PWDATA[15:0] & wmask);
                end
            end

            assign xo = xctl_r[p][psd_pkg::BIT_XOVR_CTL];
            assign manual = pause_r[p][psd_pkg::BIT_MANUAL];

            // Effective controls, registered so outputs come from flops
            always_ff @(posedge MCLK or posedge RESET) begin
                if (RESET) begin
                    MODE_BIT_A_FULL[p] <= 1'b0;
                    PHY_NEG_ENABLE[p] <= 1'b0;
                    PHY_RATE_100[p] <= 1'b0;
                    PAUSE_TX_EN[p] <= 1'b0;
                    PAUSE_RX_EN[p] <= 1'b0;
                    PAUSE_BY_NEG[p] <= 1'b0;
                    BACKPRESSURE_EN[p] <= 1'b0;
                    ADV_SYM_PAUSE[p] <= 1'b0;
                    XOVER_AUTO[p] <= 1'b0;
                    XOVER_MDIX[p] <= 1'b0;
                end else begin
                    MODE_BIT_A_FULL[p] <= basic_r[p][psd_pkg::BIT_DUPLEX]; // RULE4
                    PHY_NEG_ENABLE[p] <= basic_r[p][psd_pkg::BIT_NEG]; // RULE10
                    PHY_RATE_100[p] <= basic_r[p][psd_pkg::BIT_RATE]; // RULE12
                    // Manual select routes the enable bits; else negotiation does
                    PAUSE_TX_EN[p] <= manual && pause_r[p][psd_pkg::BIT_TX_PAUSE]; // RULE8
                    PAUSE_RX_EN[p] <= manual && pause_r[p][psd_pkg::BIT_RX_PAUSE]; // RULE8
                    PAUSE_BY_NEG[p] <= !manual && basic_r[p][psd_pkg::BIT_NEG]; // RULE9
                    BACKPRESSURE_EN[p] <= pause_r[p][psd_pkg::BIT_BACKPR]; // RULE6
                    ADV_SYM_PAUSE[p] <= adv_r[p][psd_pkg::BIT_SYM_PAUSE];
                    if (xo) begin
                        // Strap ignored entirely once overridden
                        XOVER_AUTO[p] <= xctl_r[p][psd_pkg::BIT_XOVR_AUTO]; // RULE2
                        XOVER_MDIX[p] <= xctl_r[p][psd_pkg::BIT_XOVR_MDIX]; // RULE2
                    end else begin
                        XOVER_AUTO[p] <= x_auto; // RULE1
                        // Manual pick only matters with automatic crossover off
                        XOVER_MDIX[p] <= !x_auto && x_mdix; // RULE3
                    end
                end
            end
        end
    endgenerate

    // ************************************************************
    // Read selection
    // ************************************************************
    // Unaligned or unknown addresses fall to the error answer
    always_comb begin
        rd_word = 16'h0000;
        addr_hit = 1'b0;
        if (PADDR == psd_pkg::ADDR_STRAPS) begin
            rd_word = {4'h0, strap_r};
            addr_hit = 1'b1;
        end else if (PADDR[7:6] == 2'h0) begin
            addr_hit = 1'b1;
            case (PADDR[4:0])
                psd_pkg::OFS_BASIC: begin
                    rd_word = basic_r[PADDR[5]];
                end
                psd_pkg::OFS_ADV: begin
                    rd_word = adv_r[PADDR[5]];
                end
                psd_pkg::OFS_MODES: begin
                    rd_word = modes_r[PADDR[5]];
                end
                psd_pkg::OFS_PAUSE: begin
                    rd_word = pause_r[PADDR[5]];
                end
                psd_pkg::OFS_XCTL: begin
                    rd_word = xctl_r[PADDR[5]];
                end
                default: begin
                    addr_hit = 1'b0;
                end
            endcase
        end
    end

    // ************************************************************
    // APB answer
    // ************************************************************
    // One wait state: answer registered from the first access cycle
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else if (access_first) begin
            pready_r <= 1'b1;
            // Straps image is read only; writing it is an error
            pslverr_r <= !addr_hit || (PWRITE && PADDR == psd_pkg::ADDR_STRAPS);
            prdata_r <= (PWRITE || !addr_hit) ? 32'h0000_0000 : {16'h0000, rd_word};
        end else begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end
    end

    assign PREADY = pready_r;
    assign PSLVERR = pslverr_r;
    assign PRDATA = prdata_r;

    // Busy flag registered for the outside
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            LOAD_BUSY <= 1'b1;
        end else begin
            LOAD_BUSY <= loading;
        end
    end

endmodule // psd_strap_defaults
`default_nettype wire

/* File: verification/psd_strap_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ******************************
// Strap pins or soft-strap image
// ******************************
// Levels straight from the bench
module psd_strap_model (
    input wire logic [11:0] cfg,
    output logic [1:0] duplex,
    output logic [1:0] backpressure,
    output logic [1:0] fd_pause,
    output logic [1:0] manual_pause,
    output logic xover_auto,
    output logic xover_mdix,
    output logic negotiation,
    output logic rate
);
    // Same bit order as the strap image register, so one vector sets all
    assign {rate, negotiation, xover_mdix, xover_auto, manual_pause, fd_pause, backpressure,
        duplex} = cfg;
endmodule // psd_strap_model
`default_nettype wire

/* File: verification/psd_strap_defaults_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
// ************************
// Port checks of the loader
// ************************
module psd_strap_asserts (
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic [1:0] STRAP_DUPLEX,
    input wire logic [1:0] STRAP_BACKPRESSURE,
    input wire logic [1:0] STRAP_FD_PAUSE,
    input wire logic [1:0] STRAP_MANUAL_PAUSE,
    input wire logic STRAP_NEGOTIATION_P2,
    input wire logic STRAP_RATE_P2,
    input wire logic STRAP_XOVER_AUTO_P2,
    input wire logic [1:0] MODE_BIT_A_FULL,
    input wire logic [1:0] PHY_NEG_ENABLE,
    input wire logic [1:0] PHY_RATE_100,
    input wire logic [1:0] PAUSE_TX_EN,
    input wire logic [1:0] BACKPRESSURE_EN,
    input wire logic [1:0] ADV_SYM_PAUSE,
    input wire logic [1:0] XOVER_AUTO,
    input wire logic LOAD_BUSY
);
    // One domain: shared clock and reset
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RESET);
    // Write answered this edge, landed or refused
    wire logic commit = PSEL && PENABLE && PREADY && PWRITE;
    // Straps stay put through loading, so end of load compares against live pins
    property p_duplex; $fell(LOAD_BUSY) |-> MODE_BIT_A_FULL == STRAP_DUPLEX; endproperty
    a_duplex: assert property (p_duplex) else $error("duplex default wrong");
    property p_bp; $fell(LOAD_BUSY) |-> BACKPRESSURE_EN == STRAP_BACKPRESSURE; endproperty
    a_bp: assert property (p_bp) else $error("backpressure default wrong");
    property p_tx; $fell(LOAD_BUSY) |-> PAUSE_TX_EN == (STRAP_FD_PAUSE & STRAP_MANUAL_PAUSE);
    endproperty
    a_tx: assert property (p_tx) else $error("pause default wrong");
    property p_sym; $fell(LOAD_BUSY) |-> ADV_SYM_PAUSE == ~STRAP_MANUAL_PAUSE; endproperty
    a_sym: assert property (p_sym) else $error("symmetric pause default wrong");
    property p_neg; $fell(LOAD_BUSY) |->
        {PHY_RATE_100[1], PHY_NEG_ENABLE[1]} == {STRAP_RATE_P2, STRAP_NEGOTIATION_P2};
    endproperty
    a_neg: assert property (p_neg) else $error("rate or negotiation wrong");
    property p_xover; $fell(LOAD_BUSY) |-> XOVER_AUTO[1] == STRAP_XOVER_AUTO_P2; endproperty
    a_xover: assert property (p_xover) else $error("crossover default wrong");
    // Output trails its register by one edge, hence the two-cycle look
    property p_hold; !LOAD_BUSY && !commit |-> ##2 ($stable(MODE_BIT_A_FULL) &&
        $stable(XOVER_AUTO)); endproperty
    a_hold: assert property (p_hold) else $error("output moved without a write");
    property p_ready; PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY; endproperty
    a_ready: assert property (p_ready) else $error("ready timing wrong");
    property p_roerr; PSEL && PENABLE && !PREADY && PWRITE && PADDR == psd_pkg::ADDR_STRAPS
        |=> PSLVERR; endproperty
    a_roerr: assert property (p_roerr) else $error("strap image write accepted");
    c_load: cover property ($fell(LOAD_BUSY));
    c_err: cover property (PSLVERR);
    c_write: cover property (commit);
endmodule // psd_strap_asserts

bind psd_strap_defaults psd_strap_asserts u_chk (
    .MCLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PREADY, .PSLVERR, .STRAP_DUPLEX,
    .STRAP_BACKPRESSURE, .STRAP_FD_PAUSE, .STRAP_MANUAL_PAUSE, .STRAP_NEGOTIATION_P2,
    .STRAP_RATE_P2, .STRAP_XOVER_AUTO_P2, .MODE_BIT_A_FULL, .PHY_NEG_ENABLE, .PHY_RATE_100,
    .PAUSE_TX_EN, .BACKPRESSURE_EN, .ADV_SYM_PAUSE, .XOVER_AUTO, .LOAD_BUSY
);
`default_nettype wire

/* File: verification/test_port_strap_defaults.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
// ******************
// Strap loader bench
// ******************
module test_port_strap_defaults;
    logic mclk, reset, psel, penable, pwrite, load_busy, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr;
    logic [11:0] cfg; // Strap image order
    logic [11:0] cfgs [4] = '{12'h000, 12'hFFF, 12'h6A9, 12'h956}; // Each strap both ways
    wire logic [1:0] s_dup, s_bp, s_fd, s_man;
    wire logic s_xa, s_xm, s_neg, s_rate;
    logic [1:0] dup_o, neg_o, rate_o, tx_o, rx_o, byneg_o, bp_o, sym_o, xa_o, xm_o;
    int num_errors = 0;
    int checks_done = 0;
    psd_strap_model model (.cfg(cfg), .duplex(s_dup), .backpressure(s_bp), .fd_pause(s_fd),
        .manual_pause(s_man), .xover_auto(s_xa), .xover_mdix(s_xm), .negotiation(s_neg),
        .rate(s_rate));
    psd_strap_defaults dut (
        .MCLK(mclk), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hF), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .STRAP_DUPLEX(s_dup), .STRAP_BACKPRESSURE(s_bp),
        .STRAP_FD_PAUSE(s_fd), .STRAP_MANUAL_PAUSE(s_man), .STRAP_XOVER_AUTO_P2(s_xa),
        .STRAP_XOVER_MDIX_P2(s_xm), .STRAP_NEGOTIATION_P2(s_neg), .STRAP_RATE_P2(s_rate),
        .MODE_BIT_A_FULL(dup_o), .PHY_NEG_ENABLE(neg_o), .PHY_RATE_100(rate_o),
        .PAUSE_TX_EN(tx_o), .PAUSE_RX_EN(rx_o), .PAUSE_BY_NEG(byneg_o),
        .BACKPRESSURE_EN(bp_o), .ADV_SYM_PAUSE(sym_o), .XOVER_AUTO(xa_o),
        .XOVER_MDIX(xm_o), .LOAD_BUSY(load_busy));
    // 200 MHz clock
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic conclude;
        $display("Checks %0d, errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // One APB transfer; request held until ready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            num_errors++;
            conclude();
        end
    endtask
    // Straps set under reset, held well past the load window
    task automatic boot(input logic [11:0] c);
        int n;
        n = 0;
        reset <= 1'b1;
        cfg <= c;
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        while (load_busy !== 1'b0 && n < 50) begin
            @(posedge mclk);
            n++;
        end
        if (load_busy !== 1'b0) begin
            num_errors++;
            conclude();
        end
    endtask
    // Register defaults per port p and register k (basic, advert, modes, pause)
    function automatic logic [15:0] exp_reg(input logic [11:0] c, input int p, input int k);
        logic ng, rt;
        ng = p ? c[10] : 1'b1; // Port 1 has no strap: fixed on
        rt = p ? c[11] : 1'b1;
        case (k)
            0: return {2'h0, rt, ng, 3'h0, c[p], 8'h00};
            1: return {5'h00, ~c[6+p], 3'h0, c[p] & (ng | ~rt), ng | ~rt, 5'h00};
            2: return {8'h00, ng ? psd_pkg::MODE_ALL_CAPABLE : {1'b0, rt, c[p]}, 5'h00};
            default: return {12'h000, c[6+p], c[2+p], c[4+p], c[4+p]};
        endcase
    endfunction
    initial begin
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        cfg = 12'h000;
        foreach (cfgs[i]) begin
            @(posedge mclk);
            boot(cfgs[i]);
            #1;
            `CHK("rx pause", cfg[5:4] & cfg[7:6], rx_o)
            `CHK("pause by neg", ~cfg[7:6] & {cfg[10], 1'b1}, byneg_o)
            `CHK("xover auto", {cfg[8], 1'b1}, xa_o)
            `CHK("xover mdix", {~cfg[8] & cfg[9], 1'b0}, xm_o)
            for (int p = 0; p < 2; p++) begin
                for (int k = 0; k < 4; k++) begin
                    apb(1'b0, (p ? psd_pkg::PORT2_BASE : psd_pkg::PORT1_BASE) + 8'(4 * k), 0);
                    `CHK("reg", {16'h0, exp_reg(cfg, p, k)}, rd)
                end
            end
            // Software flips the port 2 duplex; the output must follow the write
            apb(1'b1, psd_pkg::PORT2_BASE, {16'h0, exp_reg(cfg, 1, 0) ^ 16'h0100});
            cfg <= ~cfg; // Late pin move
            repeat (4) @(posedge mclk);
            #1;
            `CHK("duplex after write", cfg[1], dup_o[1])
            `CHK("late strap", {~cfg[8], 1'b1}, xa_o)
        end
        // Override set with MDIX forced: strap says automatic, must be ignored
        apb(1'b1, psd_pkg::PORT2_BASE + {3'h0, psd_pkg::OFS_XCTL}, 32'h0000A000);
        repeat (2) @(posedge mclk);
        #1;
        `CHK("override auto", 1'b0, xa_o[1])
        `CHK("override mdix", 1'b1, xm_o[1])
        apb(1'b1, psd_pkg::ADDR_STRAPS, 32'h0);
        `CHK("image write error", 1'b1, er)
        apb(1'b0, psd_pkg::ADDR_STRAPS, 32'h0);
        `CHK("strap image", {20'h0, ~cfg}, rd)
        apb(1'b0, 8'h60, 32'h0);
        `CHK("unmapped error", 1'b1, er)
        conclude();
    end
endmodule // test_port_strap_defaults
`default_nettype wire
